//--- pkg/fid_pkg.sv
// Purpose: Constants and types for the feature identification read block.
// Assumes: One core clock; reads arrive from the core's execution path.
// Notes: Field values are build options and never change after build.
// ============================================================
package fid_pkg;

  // ============================================================
  // Privilege levels and trap syndrome.
  localparam logic [1:0] FID_EL_USER = 2'h0;
  localparam logic [1:0] FID_EL_KERNEL = 2'h1;
  localparam logic [1:0] FID_EL_HYP = 2'h2;
  localparam logic [1:0] FID_EL_MON = 2'h3;
  localparam logic [5:0] FID_SYNDROME_SYSREG = 6'h18;

  // ============================================================
  // System register encodings; both registers share all but op2.
  localparam logic [1:0] FID_OP0 = 2'h3;
  localparam logic [2:0] FID_OP1 = 3'h0;
  localparam logic [3:0] FID_CRN = 4'h0;
  localparam logic [3:0] FID_CRM = 4'h4;
  localparam logic [2:0] FID_OP2_PROC_ONE = 3'h1;
  localparam logic [2:0] FID_OP2_VEC_ZERO = 3'h4;

  // ============================================================
  // Field layout of the vector feature register, lowest bit of each.
  localparam int FID_NUM_VEC_FIELDS = 9;
  // One field a line, so that each position carries its own rule.
  localparam int FID_VEC_LSB [FID_NUM_VEC_FIELDS] =
    '{56,
      52,
      44,
      40,
      32,
      20,
      16,
      4,
      0};
  // Allowed codes per field: bit n set means code n may be reported.
  localparam logic [15:0] FID_VEC_ALLOWED [FID_NUM_VEC_FIELDS] =
    '{16'h0003, 16'h0003, 16'h0003, 16'h0003, 16'h0003,
      16'h0007, 16'h0003, 16'h0005, 16'h0003};
  // Build-time field codes, in the same order as the layout above.
  localparam logic [3:0] FID_VEC_DEFAULT [FID_NUM_VEC_FIELDS] =
    '{4'h1, 4'h1, 4'h1, 4'h0, 4'h0, 4'h1, 4'h0, 4'h2, 4'h1};
  localparam logic [63:0] FID_VEC_RES0_MASK = 64'hF00F_00F0_FF00_FF00;
  localparam int FID_AES_IDX = 7;

  // ============================================================
  // Processor feature register one: branch target field.
  localparam int FID_BT_LSB = 0;
  localparam logic [15:0] FID_BT_ALLOWED = 16'h0003;
  localparam logic [3:0] FID_BT_DEFAULT = 4'h1;
  localparam logic [59:0] FID_PROC_UPPER_DEFAULT = 60'h0;

  // ============================================================
  // Outcome of an access check.
  typedef enum logic [1:0]
  {
    FID_OUT_DATA = 2'b00,
    FID_OUT_TRAP = 2'b01,
    FID_OUT_UNDEF = 2'b10
  } fid_outcome_type;

endpackage : fid_pkg

//--- pkg/fid_chk_if.sv
// Purpose: Carries one read's context to the access checker and back.
// Assumes: Purely combinational traffic within one clock cycle.
// Notes: The top drives the context, the checker returns the verdict.
interface fid_chk_if;
  logic [1:0] level;
  logic el2_enabled;
  logic trap_general;
  logic group3_trap;
  logic id_space_trap;
  logic vec_trappable;
  logic is_proc_one;
  fid_pkg::fid_outcome_type outcome;
  logic [1:0] target_level;

  modport top
  (
    output level, el2_enabled, trap_general, group3_trap, id_space_trap,
    output vec_trappable, is_proc_one,
    input outcome, target_level
  );
  modport chk
  (
    input level, el2_enabled, trap_general, group3_trap, id_space_trap,
    input vec_trappable, is_proc_one,
    output outcome, target_level
  );
endinterface : fid_chk_if

//--- core/fid_access_check.sv
// Purpose: Decides whether an identification read returns data or traps.
// Assumes: Context is stable within the cycle it is presented.
// Notes: Purely combinational; the top registers the verdict.
module fid_access_check
(
  // Context in, verdict out.
  fid_chk_if.chk chk
);

  // Privilege-dependent trap decision for both registers.
  always_comb
  begin
    chk.outcome = fid_pkg::FID_OUT_DATA;
    chk.target_level = fid_pkg::FID_EL_KERNEL;
    case (chk.level)
      fid_pkg::FID_EL_USER:
      begin
        if (chk.id_space_trap)
        begin
          chk.outcome = fid_pkg::FID_OUT_TRAP;
          if (chk.el2_enabled && chk.trap_general)
            chk.target_level = fid_pkg::FID_EL_HYP;
        end
        else
          chk.outcome = fid_pkg::FID_OUT_UNDEF;
      end
      fid_pkg::FID_EL_KERNEL:
      begin
        // The vector register only traps when the top marks it trappable.
        if (chk.el2_enabled && chk.group3_trap &&
            (chk.is_proc_one || chk.vec_trappable))
        begin
          chk.outcome = fid_pkg::FID_OUT_TRAP;
          chk.target_level = fid_pkg::FID_EL_HYP;
        end
      end
      default:
        chk.outcome = fid_pkg::FID_OUT_DATA;
    endcase
  end

endmodule : fid_access_check

//--- core/fid_feature_id_read.sv
// Purpose: Read-only feature identification registers with trap checks.
// Assumes: Requests come from core logic on i_mclk, so they are not
//   resynchronised; one request per cycle at most.
// Notes: Answers arrive one cycle after the request as a done pulse.
module fid_feature_id_read
#(
  parameter logic [3:0] P_BRANCH_TARGET = fid_pkg::FID_BT_DEFAULT,
  parameter logic [59:0] P_PROC_UPPER = fid_pkg::FID_PROC_UPPER_DEFAULT,
  parameter logic [3:0] P_VEC_FIELD [fid_pkg::FID_NUM_VEC_FIELDS] =
    fid_pkg::FID_VEC_DEFAULT,
  parameter bit P_VEC_REG_NAMED = 1'b1,
  parameter bit P_ID_SPACE_TRAP = 1'b1,
  parameter bit P_FINE_GRAINED_TRAP = 1'b0,
  parameter bit P_VEC_TRAP_OPTION = 1'b0,
  parameter bit P_STANDALONE_VECTOR = 1'b0,
  parameter bit P_MATRIX_EXT = 1'b1
)
(
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // System register read request.
  input wire logic i_rd_valid,
  input wire logic [1:0] i_op0,
  input wire logic [2:0] i_op1,
  input wire logic [3:0] i_crn,
  input wire logic [3:0] i_crm,
  input wire logic [2:0] i_op2,
  // Processor state and hypervisor controls.
  input wire logic [1:0] i_current_privilege_level,
  input wire logic i_el2_enabled,
  input wire logic i_hyp_trap_general_exceptions,
  input wire logic i_hyp_id_group3_trap,
  // Vector instruction gating request.
  input wire logic i_vec_insn_valid,
  input wire logic i_streaming_mode,
  input wire logic i_vec_insn_streaming_legal,
  // Read answer.
  output logic o_rd_done,
  output logic o_rd_hit,
  output logic [63:0] o_rd_data,
  output logic o_trap,
  output logic [1:0] o_trap_level,
  output logic [5:0] o_syndrome_class,
  output logic o_undefined,
  // Vector instruction gating answer.
  output logic o_vec_insn_allow
);

  // ============================================================
  // Reset synchroniser.
  logic rst_meta_b;
  logic rst_b;

  // Release is synchronised; assertion is still immediate.
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_meta_b <= 1'b0;
      rst_b <= 1'b0;
    end
    else
    begin
      rst_meta_b <= 1'b1;
      rst_b <= rst_meta_b;
    end
  end

  // ============================================================
  // Register contents, built from parameters only.
  logic [3:0] branch_target_support;
  logic [63:0] processor_feature_id_one;
  logic [63:0] vec_fields;
  logic [63:0] vector_feature_id_zero;
  logic [3:0] vec_code [fid_pkg::FID_NUM_VEC_FIELDS];

  // A reserved build value is reported as absent rather than guessed.
  assign branch_target_support =
    fid_pkg::FID_BT_ALLOWED[P_BRANCH_TARGET] ? P_BRANCH_TARGET : 4'h0;
  assign processor_feature_id_one =
    {P_PROC_UPPER, branch_target_support};

  // Each field is legalised against its allowed set of codes.
  genvar gi;
  generate
    for (gi = 0; gi < fid_pkg::FID_NUM_VEC_FIELDS; gi++)
    begin : g_vec_field
      // Rounds-only cipher code is never reported; it drops to absent.
      assign vec_code[gi] =
        fid_pkg::FID_VEC_ALLOWED[gi][P_VEC_FIELD[gi]] ?
        P_VEC_FIELD[gi] : 4'h0;
      assign vec_fields[fid_pkg::FID_VEC_LSB[gi] +: 4] =
        vec_code[gi];
    end
  endgenerate

  // Bits outside the listed fields are reserved and read zero.
  assign vec_fields[63:60] = 4'h0;
  assign vec_fields[51:48] = 4'h0;
  assign vec_fields[39:36] = 4'h0;
  assign vec_fields[31:24] = 8'h00;
  assign vec_fields[15:8] = 8'h00;

  // An older build leaves the location unnamed and all zero.
  assign vector_feature_id_zero =
    P_VEC_REG_NAMED ? vec_fields : 64'h0;

  // ============================================================
  // Request decode.
  logic enc_common;
  logic hit_proc_one;
  logic hit_vec_zero;
  logic hit;

  // Both registers share all fields except op2.
  assign enc_common = (i_op0 == fid_pkg::FID_OP0) &&
    (i_op1 == fid_pkg::FID_OP1) && (i_crn == fid_pkg::FID_CRN) &&
    (i_crm == fid_pkg::FID_CRM);
  assign hit_proc_one = enc_common &&
    (i_op2 == fid_pkg::FID_OP2_PROC_ONE);
  assign hit_vec_zero = enc_common &&
    (i_op2 == fid_pkg::FID_OP2_VEC_ZERO);
  assign hit = hit_proc_one || hit_vec_zero;

  // ============================================================
  // Access check.
  fid_chk_if chk_bus ();

  // The vector register is trappable when it is nonzero, or when fine-grained trapping or the vector trap option is built in.
  assign chk_bus.level = i_current_privilege_level;
  assign chk_bus.el2_enabled = i_el2_enabled;
  assign chk_bus.trap_general = i_hyp_trap_general_exceptions;
  assign chk_bus.group3_trap = i_hyp_id_group3_trap;
  assign chk_bus.id_space_trap = P_ID_SPACE_TRAP;
  assign chk_bus.vec_trappable = P_FINE_GRAINED_TRAP ||
    (vector_feature_id_zero != 64'h0) || P_VEC_TRAP_OPTION;
  assign chk_bus.is_proc_one = hit_proc_one;

  fid_access_check u_check
  (
    .chk(chk_bus)
  );

  // ============================================================
  // Answer registers.
  logic [63:0] next_rd_data;

  // Selected register value; there is no write path at all.
  always_comb
  begin
    next_rd_data = 64'h0;
    if (hit_proc_one)
      next_rd_data = processor_feature_id_one;
    else if (hit_vec_zero)
      next_rd_data = vector_feature_id_zero;
  end

  // Completion flag pulses for one cycle after each request, the hit flag only after a mapped one.
  always_ff @(posedge i_mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      o_rd_done <= 1'b0;
      o_rd_hit <= 1'b0;
    end
    else
    begin
      o_rd_done <= i_rd_valid;
      o_rd_hit <= i_rd_valid && hit;
    end
  end

  // Verdict and data; data is withheld on a trap or undefined read.
  always_ff @(posedge i_mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      o_rd_data <= 64'h0;
      o_trap <= 1'b0;
      o_trap_level <= 2'h0;
      o_syndrome_class <= 6'h00;
      o_undefined <= 1'b0;
    end
    else
    begin
      o_rd_data <= 64'h0;
      o_trap <= 1'b0;
      o_trap_level <= 2'h0;
      o_syndrome_class <= 6'h00;
      o_undefined <= 1'b0;
      if (i_rd_valid && hit)
      begin
        case (chk_bus.outcome)
          fid_pkg::FID_OUT_DATA:
            o_rd_data <= next_rd_data;
          fid_pkg::FID_OUT_TRAP:
          begin
            o_trap <= 1'b1;
            o_trap_level <= chk_bus.target_level;
            o_syndrome_class <= fid_pkg::FID_SYNDROME_SYSREG;
          end
          fid_pkg::FID_OUT_UNDEF:
            o_undefined <= 1'b1;
          default:
            o_undefined <= 1'b1;
        endcase
      end
    end
  end

  // ============================================================
  // Vector instruction gating.
  // Without a standalone vector unit only streaming-legal ops may run.
  always_ff @(posedge i_mclk or negedge rst_b)
  begin
    if (!rst_b)
      o_vec_insn_allow <= 1'b0;
    else
      o_vec_insn_allow <= i_vec_insn_valid && (P_STANDALONE_VECTOR ||
        (P_MATRIX_EXT && i_streaming_mode &&
         i_vec_insn_streaming_legal));
  end

  // ============================================================
  // Assertions.
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_b);

  sequence user_read_s;
    i_rd_valid && hit &&
      (i_current_privilege_level == fid_pkg::FID_EL_USER);
  endsequence

  sequence kernel_read_s;
    i_rd_valid && hit &&
      (i_current_privilege_level == fid_pkg::FID_EL_KERNEL);
  endsequence

  sequence high_read_s;
    i_rd_valid && hit &&
      (i_current_privilege_level[1] == 1'b1);
  endsequence

  sequence trap_answer_s;
    o_rd_done && o_rd_hit && o_trap && !o_undefined &&
      (o_syndrome_class == fid_pkg::FID_SYNDROME_SYSREG) &&
      (o_rd_data == 64'h0);
  endsequence

  sequence data_answer_s;
    o_rd_done && o_rd_hit && !o_trap && !o_undefined &&
      (o_syndrome_class == 6'h00) && (o_trap_level == 2'h0);
  endsequence

  user_trap_class_a: assert property (
    user_read_s and (P_ID_SPACE_TRAP == 1'b1) |=> trap_answer_s and
      (o_trap_level == ($past(i_el2_enabled &&
        i_hyp_trap_general_exceptions) ? fid_pkg::FID_EL_HYP :
        fid_pkg::FID_EL_KERNEL)))
    else $error("User read did not trap to the right level.");

  user_undef_a: assert property (
    user_read_s and (P_ID_SPACE_TRAP == 1'b0) |=>
      o_undefined && !o_trap && (o_rd_data == 64'h0))
    else $error("User read without trap feature was not undefined.");

  kernel_proc_trap_a: assert property (
    kernel_read_s and (hit_proc_one && i_el2_enabled &&
      i_hyp_id_group3_trap) |=> trap_answer_s and
      (o_trap_level == fid_pkg::FID_EL_HYP))
    else $error("Kernel read of feature one did not trap.");

  kernel_proc_data_a: assert property (
    kernel_read_s and (hit_proc_one &&
      !(i_el2_enabled && i_hyp_id_group3_trap)) |=>
      !o_trap && (o_rd_data == processor_feature_id_one))
    else $error("Kernel read of feature one lost its data.");

  high_level_data_a: assert property (
    high_read_s |=> o_rd_done && !o_trap && !o_undefined &&
      (o_rd_data == $past(next_rd_data)))
    else $error("High level read did not return the value.");

  kernel_vec_trap_a: assert property (
    kernel_read_s and hit_vec_zero |=>
      (o_trap == $past(i_el2_enabled && i_hyp_id_group3_trap &&
        chk_bus.vec_trappable)))
    else $error("Kernel vector read trap decision is wrong.");

  vec_reserved_zero_a: assert property (
    i_rd_valid && hit_vec_zero |=>
      ((o_rd_data & fid_pkg::FID_VEC_RES0_MASK) == 64'h0))
    else $error("Reserved vector bits read nonzero.");

  cipher_code_legal_a: assert property (
    o_rd_done ##0 $past(hit_vec_zero) |->
      (o_rd_data[7:4] == 4'h0) || (o_rd_data[7:4] == 4'h2))
    else $error("Cipher rounds field reports an illegal code.");

  vec_gate_a: assert property (
    i_vec_insn_valid && !P_STANDALONE_VECTOR && !i_streaming_mode |=>
      !o_vec_insn_allow)
    else $error("Vector op allowed outside streaming mode.");

  unmapped_read_a: assert property (
    i_rd_valid && !hit |=> o_rd_done && !o_rd_hit && !o_trap &&
      !o_undefined && (o_rd_data == 64'h0))
    else $error("Unmapped read gave a non-empty answer.");

  // Field codes must stay inside their legal sets whatever the build says.
  branch_target_code_a: assert property (
    i_rd_valid && hit_proc_one |=>
      (o_rd_data[3:0] == 4'h0) || (o_rd_data[3:0] == 4'h1))
    else $error("Branch target field reports a reserved code.");

  kernel_vec_data_a: assert property (
    kernel_read_s and (hit_vec_zero && !(i_el2_enabled &&
      i_hyp_id_group3_trap)) |=> data_answer_s and
      (o_rd_data == vector_feature_id_zero))
    else $error("Kernel vector read lost its data.");

  matmul_codes_a: assert property (
    i_rd_valid && hit_vec_zero |=> (o_rd_data[59:56] <= 4'h1) &&
      (o_rd_data[55:52] <= 4'h1) && (o_rd_data[47:44] <= 4'h1))
    else $error("Matrix multiply field reports a reserved code.");

  vec_field_codes_a: assert property (
    i_rd_valid && hit_vec_zero |=> (o_rd_data[3:0] <= 4'h1) &&
      (o_rd_data[23:20] <= 4'h2) && (o_rd_data[19:16] <= 4'h1))
    else $error("Vector register field reports a reserved code.");

  vec_gate_allow_a: assert property (
    i_vec_insn_valid && P_MATRIX_EXT && i_streaming_mode &&
      i_vec_insn_streaming_legal |=> o_vec_insn_allow)
    else $error("Streaming-legal vector op was refused.");

  // Answers are pulses; nothing may linger once requests stop.
  read_idle_quiet_a: assert property (
    !i_rd_valid |=> !o_rd_done && !o_rd_hit && !o_trap &&
      !o_undefined && (o_rd_data == 64'h0))
    else $error("Answer outputs active without a request.");

  undef_quiet_a: assert property (
    o_undefined |-> !o_trap && (o_syndrome_class == 6'h00) &&
      (o_trap_level == 2'h0) && (o_rd_data == 64'h0))
    else $error("Undefined read carried trap or data.");

endmodule : fid_feature_id_read

//--- tb/fid_core_model.sv
// Purpose: Model of the core pipeline that issues identification reads.
// Assumes: The bench commands it at the rising edge of i_mclk.
// Notes: Idle encoding lines invert every cycle, so the last encoding comes back every second idle cycle.
module fid_core_model
(
  // Clock.
  input wire logic i_mclk,
  // Command from the bench.
  input wire logic i_go,
  input wire logic [2:0] i_op2,
  // Request towards the block.
  output logic o_rd_valid,
  output logic [1:0] o_op0,
  output logic [2:0] o_op1,
  output logic [3:0] o_crn,
  output logic [3:0] o_crm,
  output logic [2:0] o_op2
);
  timeunit 1ns;
  timeprecision 1ps;

  // ============================================================
  // Request launch
  // Start quiet so the block sees known lines from time zero.
  initial
  begin
    o_rd_valid = 1'b0;
    o_op0 = 2'h0;
    o_op1 = 3'h0;
    o_crn = 4'h0;
    o_crm = 4'h0;
    o_op2 = 3'h0;
  end

  // A request changes just after an edge and holds for the whole cycle.
  always @(posedge i_mclk)
  begin
    o_rd_valid <= i_go;
    if (i_go)
    begin
      o_op0 <= 2'h3;
      o_op1 <= 3'h0;
      o_crn <= 4'h0;
      o_crm <= 4'h4;
      o_op2 <= i_op2;
    end
    else
    begin
      o_op0 <= ~o_op0;
      o_op1 <= ~o_op1;
      o_crn <= ~o_crn;
      o_crm <= ~o_crm;
      o_op2 <= ~o_op2;
    end
  end
endmodule : fid_core_model

//--- tb/feature_id_register_read_bench.sv
// Purpose: Self-checking bench for the feature identification read block.
// Assumes: Default build options on uut, a reduced build on uut_b.
// Notes: Expected values come from the package's build constants.
module feature_id_register_read_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_mclk, i_rst_b, go, el2, tge, g3, vv, strm, legal;
  logic [2:0] cmd_op2, op1, op2;
  logic [1:0] lvl, op0, tlvl;
  logic [3:0] crn, crm;
  logic rd_valid, done, hit, trap, undef, allow, undef_b;
  logic [63:0] data, data_b, vec_val;
  logic [5:0] syn;
  int miscompares, n_tests, cycles;
  localparam logic [63:0] PROC_VAL =
    {fid_pkg::FID_PROC_UPPER_DEFAULT, fid_pkg::FID_BT_DEFAULT};

  // ============================================================
  // Instances
  fid_core_model core (.i_mclk(i_mclk), .i_go(go), .i_op2(cmd_op2),
    .o_rd_valid(rd_valid), .o_op0(op0), .o_op1(op1), .o_crn(crn),
    .o_crm(crm), .o_op2(op2));
  fid_feature_id_read uut (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_rd_valid(rd_valid), .i_op0(op0), .i_op1(op1), .i_crn(crn),
    .i_crm(crm), .i_op2(op2), .i_current_privilege_level(lvl),
    .i_el2_enabled(el2), .i_hyp_trap_general_exceptions(tge),
    .i_hyp_id_group3_trap(g3), .i_vec_insn_valid(vv),
    .i_streaming_mode(strm), .i_vec_insn_streaming_legal(legal),
    .o_rd_done(done), .o_rd_hit(hit), .o_rd_data(data), .o_trap(trap),
    .o_trap_level(tlvl), .o_syndrome_class(syn), .o_undefined(undef),
    .o_vec_insn_allow(allow));
  // Reduced build: no trap feature, vector location still unnamed.
  fid_feature_id_read #(.P_ID_SPACE_TRAP(1'b0), .P_VEC_REG_NAMED(1'b0))
    uut_b (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_rd_valid(rd_valid), .i_op0(op0), .i_op1(op1), .i_crn(crn),
    .i_crm(crm), .i_op2(op2), .i_current_privilege_level(lvl),
    .i_el2_enabled(el2), .i_hyp_trap_general_exceptions(tge),
    .i_hyp_id_group3_trap(g3), .i_vec_insn_valid(vv),
    .i_streaming_mode(strm), .i_vec_insn_streaming_legal(legal),
    .o_rd_done(), .o_rd_hit(), .o_rd_data(data_b), .o_trap(),
    .o_trap_level(), .o_syndrome_class(), .o_undefined(undef_b),
    .o_vec_insn_allow());

  // ============================================================
  // Clock and timeout
  // Free-running 100 MHz core clock.
  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  // A hung run is cut short well beyond the eighty or so cycles needed.
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  // ============================================================
  // Shared tasks
  task automatic give_verdict();
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic chk_data(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_ctl(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_ctl

  // One read; returns just after the edge that shows the answer.
  task automatic issue(input logic [2:0] o2, input logic [1:0] l);
    int k;
    k = 0;
    @(posedge i_mclk);
    go <= 1'b1;
    cmd_op2 <= o2;
    lvl <= l;
    @(posedge i_mclk);
    go <= 1'b0;
    @(posedge i_mclk);
    #1;
    while (done !== 1'b1 && k < 6)
    begin
      @(posedge i_mclk);
      #1;
      k++;
    end
  endtask : issue

  task automatic expect_rd(input logic h, input logic [63:0] d,
    input logic t, input logic [1:0] tl, input logic u);
    chk_ctl({4'h0, done, hit, trap, undef}, {4'h0, 1'b1, h, t, u});
    chk_data(data, d);
    chk_ctl({tlvl, syn}, {tl, (t ? 6'h18 : 6'h00)});
  endtask : expect_rd

  // ============================================================
  // Scenarios
  task automatic t_high_levels();
    issue(3'h1, 2'h2);
    expect_rd(1'b1, PROC_VAL, 1'b0, 2'h0, 1'b0);
    issue(3'h1, 2'h3);
    expect_rd(1'b1, PROC_VAL, 1'b0, 2'h0, 1'b0);
    issue(3'h4, 2'h2);
    expect_rd(1'b1, vec_val, 1'b0, 2'h0, 1'b0);
    chk_data(data_b, 64'h0);
    issue(3'h4, 2'h3);
    expect_rd(1'b1, vec_val, 1'b0, 2'h0, 1'b0);
  endtask : t_high_levels

  // User reads trap to the level that the controls pick, or are undefined.
  task automatic t_user();
    logic [1:0] want;
    for (int i = 0; i < 3; i++)
    begin
      el2 <= (i != 2);
      tge <= (i != 1);
      want = (i == 0) ? 2'h2 : 2'h1;
      issue(3'h1, 2'h0);
      expect_rd(1'b1, 64'h0, 1'b1, want, 1'b0);
      chk_ctl({7'h0, undef_b}, 8'h01);
      issue(3'h4, 2'h0);
      expect_rd(1'b1, 64'h0, 1'b1, want, 1'b0);
    end
  endtask : t_user

  task automatic t_kernel();
    el2 <= 1'b1;
    g3 <= 1'b1;
    issue(3'h1, 2'h1);
    expect_rd(1'b1, 64'h0, 1'b1, 2'h2, 1'b0);
    issue(3'h4, 2'h1);
    expect_rd(1'b1, 64'h0, 1'b1, 2'h2, 1'b0);
    el2 <= 1'b0;
    issue(3'h1, 2'h1);
    expect_rd(1'b1, PROC_VAL, 1'b0, 2'h0, 1'b0);
    issue(3'h4, 2'h1);
    expect_rd(1'b1, vec_val, 1'b0, 2'h0, 1'b0);
    chk_data(data_b, 64'h0);
    g3 <= 1'b0;
  endtask : t_kernel

  // Unmapped encoding, then two reads on consecutive cycles.
  task automatic t_unmapped_b2b();
    issue(3'h0, 2'h2);
    expect_rd(1'b0, 64'h0, 1'b0, 2'h0, 1'b0);
    @(posedge i_mclk);
    go <= 1'b1;
    cmd_op2 <= 3'h1;
    @(posedge i_mclk);
    cmd_op2 <= 3'h4;
    @(posedge i_mclk);
    go <= 1'b0;
    #1;
    expect_rd(1'b1, PROC_VAL, 1'b0, 2'h0, 1'b0);
    @(posedge i_mclk);
    #1;
    expect_rd(1'b1, vec_val, 1'b0, 2'h0, 1'b0);
  endtask : t_unmapped_b2b

  // Matrix build without standalone vector: only streaming-legal ops pass.
  task automatic t_gate();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge i_mclk);
      vv <= 1'b1;
      strm <= i[1];
      // Only ops flagged streaming-legal are expected to run here.
      legal <= i[0];
      @(posedge i_mclk);
      #1;
      chk_ctl({7'h0, allow}, {7'h0, (i == 3)});
    end
    vv <= 1'b0;
  endtask : t_gate

  // A reset in mid-run swallows a pending read and keeps the contents.
  task automatic t_reset();
    @(posedge i_mclk);
    i_rst_b <= 1'b0;
    go <= 1'b1;
    cmd_op2 <= 3'h1;
    lvl <= 2'h2;
    @(posedge i_mclk);
    go <= 1'b0;
    @(posedge i_mclk);
    #1;
    chk_ctl({4'h0, done, hit, trap, undef}, 8'h00);
    chk_data(data, 64'h0);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_mclk);
    issue(3'h1, 2'h2);
    expect_rd(1'b1, PROC_VAL, 1'b0, 2'h0, 1'b0);
  endtask : t_reset

  // ============================================================
  // Main sequence
  // Expected vector value is built from the field layout constants.
  initial
  begin
    vec_val = 64'h0;
    for (int k = 0; k < fid_pkg::FID_NUM_VEC_FIELDS; k++)
      vec_val[fid_pkg::FID_VEC_LSB[k] +: 4] = fid_pkg::FID_VEC_DEFAULT[k];
    {i_rst_b, go, el2, tge, g3, vv, strm, legal} = 8'h00;
    cmd_op2 = 3'h0;
    lvl = 2'h0;
    repeat (10) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_mclk);
    t_high_levels();
    t_user();
    t_kernel();
    t_unmapped_b2b();
    t_gate();
    t_reset();
    give_verdict();
  end
endmodule : feature_id_register_read_bench
